// File: core/tic_pkg.sv
// Constants, register map and types of the two-level interrupt controller
package tic_pkg;

  // ****************************************
  // Sizes
  // ****************************************
  localparam int NUM_PER_REGS = 5;
  localparam int PER_SRC      = 8 * NUM_PER_REGS;
  localparam int NUM_CORE     = 5;
  localparam int NUM_EXT      = 3;
  localparam int NUM_IOC      = 4;
  localparam int PC_W         = 16;

  // ****************************************
  // Register byte offsets
  // ****************************************
  localparam logic [7:0] OFS_CTRL   = 8'h00;
  localparam logic [7:0] OFS_CTRL2  = 8'h04;
  localparam logic [7:0] OFS_CTRL3  = 8'h08;
  localparam logic [7:0] OFS_PFLAG0 = 8'h10;
  localparam logic [7:0] OFS_PEN0   = 8'h30;
  localparam logic [7:0] OFS_PPRI0  = 8'h50;
  localparam logic [7:0] OFS_RSTCTL = 8'h70;
  localparam logic [7:0] OFS_STATUS = 8'h74;

  // ****************************************
  // Reset values and writable masks
  // ****************************************
  localparam logic [7:0] RST_CTRL   = 8'h00;
  localparam logic [7:0] RST_CTRL2  = 8'hf5;
  localparam logic [7:0] RST_CTRL3  = 8'hc0;
  localparam logic [7:0] RST_PFLAG  = 8'h00;
  localparam logic [7:0] RST_PEN    = 8'h00;
  localparam logic [7:0] RST_PPRI   = 8'hff;
  localparam logic [7:0] RST_RSTCTL = 8'h00;
  localparam logic [7:0] MASK_ALL   = 8'hff;
  localparam logic [7:0] MASK_CTRL2 = 8'hf5;
  localparam logic [7:0] MASK_CTRL3 = 8'hdb;
  localparam logic [7:0] MASK_RSTCTL = 8'h80;

  // ****************************************
  // Field positions
  // ****************************************
  localparam int CTRL_GH     = 7;
  localparam int CTRL_GL     = 6;
  localparam int CTRL_TMR_EN = 5;
  localparam int CTRL_E0_EN  = 4;
  localparam int CTRL_IOC_EN = 3;
  localparam int CTRL_TMR_FL = 2;
  localparam int CTRL_E0_FL  = 1;
  localparam int CTRL_IOC_FL = 0;
  localparam int CTRL2_EDGE0 = 6;
  localparam int CTRL2_EDGE1 = 5;
  localparam int CTRL2_EDGE2 = 4;
  localparam int CTRL2_TMR_PRI = 2;
  localparam int CTRL2_IOC_PRI = 0;
  localparam int CTRL3_E2_PRI = 7;
  localparam int CTRL3_E1_PRI = 6;
  localparam int CTRL3_E2_EN  = 4;
  localparam int CTRL3_E1_EN  = 3;
  localparam int CTRL3_E2_FL  = 1;
  localparam int CTRL3_E1_FL  = 0;
  localparam int RSTCTL_PRIO  = 7;

  // ****************************************
  // Vectors
  // ****************************************
  localparam logic [PC_W-1:0] VEC_HIGH = 16'h0008;
  localparam logic [PC_W-1:0] VEC_LOW  = 16'h0018;

  typedef enum logic [1:0] {SEQ_IDLE, SEQ_PUSH, SEQ_LOAD} tic_seq_t;

endpackage

// File: core/tic_flag_reg.sv
// Byte register with software write and hardware set and clear
`timescale 1ns/1ps
module tic_flag_reg
  import tic_pkg::*;
#(
  parameter logic [7:0] RST_VAL = 8'h00,
  parameter logic [7:0] WR_MASK = 8'hff
)(
  input  wire logic       clk,
  input  wire logic       rstn,
  input  wire logic       wrEn,
  input  wire logic [7:0] wrData,
  input  wire logic [7:0] hwSet,
  input  wire logic [7:0] hwClr,
  output logic      [7:0] value
);

  logic [7:0] value_q;
  logic [7:0] value_d;

  // Hardware set is applied last so an event never loses to a clear
  always_comb
  begin
    value_d = value_q;
    if (wrEn)
    begin
      value_d = (value_q & ~WR_MASK) | (wrData & WR_MASK);
    end
    value_d = (value_d & ~hwClr) | hwSet;
  end

  always_ff @(posedge clk or negedge rstn)
  begin
    if (!rstn)
    begin
      value_q <= RST_VAL;
    end
    else
    begin
      value_q <= value_d;
    end
  end

  assign value = value_q;

endmodule // tic_flag_reg

// File: core/tic_pin_sync.sv
// Two-stage synchroniser with edge detection for pin inputs
`timescale 1ns/1ps
module tic_pin_sync
  import tic_pkg::*;
#(
  parameter int N = 1
)(
  input  wire logic         clk,
  input  wire logic         rstn,
  input  wire logic [N-1:0] pinIn,
  output logic      [N-1:0] rise,
  output logic      [N-1:0] fall
);

  logic [N-1:0] meta_q;
  logic [N-1:0] sync_q;
  logic [N-1:0] last_q;

  // Only the second stage reads the first one
  always_ff @(posedge clk or negedge rstn)
  begin
    if (!rstn)
    begin
      meta_q <= '0;
      sync_q <= '0;
      last_q <= '0;
    end
    else
    begin
      meta_q <= pinIn;
      sync_q <= meta_q;
      last_q <= sync_q;
    end
  end

  assign rise = sync_q & ~last_q;
  assign fall = ~sync_q & last_q;

endmodule // tic_pin_sync

// File: core/tic_interrupt_controller.sv
// Two-level interrupt controller with Wishbone register access
//
// What this block does
// - External line zero is always high priority and has no priority bit.
// - Priority mode vectors high requests to 0008h and low requests to 0018h.
// - An enabled high request preempts a running low service routine.
// - Priority mode enable bit in reset control selects mode; clear by default.
// - Compatibility mode ignores every per-source priority bit.
// - Compatibility: peripherals need both peripheral and global enable set.
// - Compatibility: global enable opens core sources; clear masks everything.
// - Compatibility mode vectors every accepted interrupt to 0008h.
// - Priority mode: high enable opens high sources; clear masks all sources.
// - Priority mode: low enable gates low sources, needs high enable too.
// - Flag, own enable and global enable all set trigger vectoring.
// - Responding clears the single, high or low global enable as applicable.
// - No low request is taken while a high routine is active.
// - Acceptance pushes the return address then loads the vector.
// - Return from interrupt leaves the routine and sets the enable again.
// - Pin events set their flag three clocks later and reach the vector at the third boundary after it.
// - Flags set on events regardless of any enable, for polling.
// - Five flag, five enable and five priority peripheral registers.
`timescale 1ns/1ps
module tic_interrupt_controller
  import tic_pkg::*;
(
  input  wire logic               ref_clk,
  input  wire logic               rstn,
  input  wire logic               wb_cyc_i,
  input  wire logic               wb_stb_i,
  input  wire logic               wb_we_i,
  input  wire logic [7:0]         wb_adr_i,
  input  wire logic [3:0]         wb_sel_i,
  input  wire logic [31:0]        wb_dat_i,
  output logic      [31:0]        wb_dat_o,
  output logic                    wb_ack_o,
  input  wire logic [NUM_EXT-1:0] externalLinePin,
  input  wire logic [NUM_IOC-1:0] portChangePin,
  input  wire logic               timerOvfEvt,
  input  wire logic [PER_SRC-1:0] periphEvt,
  input  wire logic               instrEnd,
  input  wire logic               returnFromIsrInstr,
  input  wire logic [PC_W-1:0]    returnAddr,
  output logic                    stackPush,
  output logic      [PC_W-1:0]    stackPushAddr,
  output logic                    pcLoad,
  output logic      [PC_W-1:0]    pcLoadAddr,
  output logic                    isrHighActive,
  output logic                    isrLowActive
);

  // ****************************************
  // Reset release
  // ****************************************
  logic rstnMeta_q;
  logic rstnSync_q;

  always_ff @(posedge ref_clk or negedge rstn)
  begin
    if (!rstn)
    begin
      rstnMeta_q <= 1'b0;
      rstnSync_q <= 1'b0;
    end
    else
    begin
      rstnMeta_q <= 1'b1;
      rstnSync_q <= rstnMeta_q;
    end
  end

  // ****************************************
  // Wishbone slave
  // ****************************************
  logic        ack_q;
  logic [31:0] rdData_q;
  logic [7:0]  rdByte;
  logic        wbWr;

  function automatic logic hit(input logic [7:0] adr, input logic [7:0] ofs);
    return adr[7:2] == ofs[7:2];
  endfunction

  // Writes land on the edge where the master samples ack
  assign wbWr = wb_cyc_i & wb_stb_i & wb_we_i & ack_q & wb_sel_i[0];

  always_ff @(posedge ref_clk or negedge rstnSync_q)
  begin
    if (!rstnSync_q)
    begin
      ack_q    <= 1'b0;
      rdData_q <= 32'h0000_0000;
    end
    else
    begin
      ack_q <= wb_cyc_i & wb_stb_i & ~ack_q;
      if (wb_cyc_i && wb_stb_i && !ack_q)
      begin
        rdData_q <= {24'h00_0000, rdByte};
      end
    end
  end

  assign wb_ack_o = ack_q;
  assign wb_dat_o = rdData_q;

  // ****************************************
  // Event capture
  // ****************************************
  logic [NUM_EXT-1:0] extRise;
  logic [NUM_EXT-1:0] extFall;
  logic [NUM_IOC-1:0] iocRise;
  logic [NUM_IOC-1:0] iocFall;
  logic [NUM_EXT-1:0] extEvt;
  logic               iocEvt;
  logic [7:0]         ctrlVal;
  logic [7:0]         ctrl2Val;
  logic [7:0]         ctrl3Val;
  logic [7:0]         rstCtlVal;
  logic [7:0]         ctrlSet;
  logic [7:0]         ctrlClr;

  tic_pin_sync #(.N(NUM_EXT)) u_ext_sync (
    .clk   (ref_clk),
    .rstn  (rstnSync_q),
    .pinIn (externalLinePin),
    .rise  (extRise),
    .fall  (extFall)
  );

  tic_pin_sync #(.N(NUM_IOC)) u_ioc_sync (
    .clk   (ref_clk),
    .rstn  (rstnSync_q),
    .pinIn (portChangePin),
    .rise  (iocRise),
    .fall  (iocFall)
  );

  assign extEvt[0] = ctrl2Val[CTRL2_EDGE0] ? extRise[0] : extFall[0];
  assign extEvt[1] = ctrl2Val[CTRL2_EDGE1] ? extRise[1] : extFall[1];
  assign extEvt[2] = ctrl2Val[CTRL2_EDGE2] ? extRise[2] : extFall[2];
  assign iocEvt    = |(iocRise | iocFall);

  // ****************************************
  // Control registers
  // ****************************************
  tic_flag_reg #(.RST_VAL(RST_CTRL), .WR_MASK(MASK_ALL)) u_ctrl (
    .clk    (ref_clk),
    .rstn   (rstnSync_q),
    .wrEn   (wbWr & hit(wb_adr_i, OFS_CTRL)),
    .wrData (wb_dat_i[7:0]),
    .hwSet  (ctrlSet),
    .hwClr  (ctrlClr),
    .value  (ctrlVal)
  );

  tic_flag_reg #(.RST_VAL(RST_CTRL2), .WR_MASK(MASK_CTRL2)) u_ctrl2 (
    .clk    (ref_clk),
    .rstn   (rstnSync_q),
    .wrEn   (wbWr & hit(wb_adr_i, OFS_CTRL2)),
    .wrData (wb_dat_i[7:0]),
    .hwSet  (8'h00),
    .hwClr  (8'h00),
    .value  (ctrl2Val)
  );

  // Flags set from events whatever the enables say
  tic_flag_reg #(.RST_VAL(RST_CTRL3), .WR_MASK(MASK_CTRL3)) u_ctrl3 (
    .clk    (ref_clk),
    .rstn   (rstnSync_q),
    .wrEn   (wbWr & hit(wb_adr_i, OFS_CTRL3)),
    .wrData (wb_dat_i[7:0]),
    .hwSet  ({6'h00, extEvt[2], extEvt[1]}),
    .hwClr  (8'h00),
    .value  (ctrl3Val)
  );

  // Priority mode select
  tic_flag_reg #(.RST_VAL(RST_RSTCTL), .WR_MASK(MASK_RSTCTL)) u_rstctl (
    .clk    (ref_clk),
    .rstn   (rstnSync_q),
    .wrEn   (wbWr & hit(wb_adr_i, OFS_RSTCTL)),
    .wrData (wb_dat_i[7:0]),
    .hwSet  (8'h00),
    .hwClr  (8'h00),
    .value  (rstCtlVal)
  );

  // ****************************************
  // Peripheral registers
  // ****************************************
  logic [7:0] perFlag [NUM_PER_REGS];
  logic [7:0] perEn   [NUM_PER_REGS];
  logic [7:0] perPri  [NUM_PER_REGS];

  for (genvar i = 0; i < NUM_PER_REGS; i++)
  begin : g_per
    tic_flag_reg #(.RST_VAL(RST_PFLAG), .WR_MASK(MASK_ALL)) u_flag (
      .clk    (ref_clk),
      .rstn   (rstnSync_q),
      .wrEn   (wbWr & hit(wb_adr_i, 8'(OFS_PFLAG0 + 8'(4 * i)))),
      .wrData (wb_dat_i[7:0]),
      .hwSet  (periphEvt[8*i +: 8]),
      .hwClr  (8'h00),
      .value  (perFlag[i])
    );
    tic_flag_reg #(.RST_VAL(RST_PEN), .WR_MASK(MASK_ALL)) u_en (
      .clk    (ref_clk),
      .rstn   (rstnSync_q),
      .wrEn   (wbWr & hit(wb_adr_i, 8'(OFS_PEN0 + 8'(4 * i)))),
      .wrData (wb_dat_i[7:0]),
      .hwSet  (8'h00),
      .hwClr  (8'h00),
      .value  (perEn[i])
    );
    tic_flag_reg #(.RST_VAL(RST_PPRI), .WR_MASK(MASK_ALL)) u_pri (
      .clk    (ref_clk),
      .rstn   (rstnSync_q),
      .wrEn   (wbWr & hit(wb_adr_i, 8'(OFS_PPRI0 + 8'(4 * i)))),
      .wrData (wb_dat_i[7:0]),
      .hwSet  (8'h00),
      .hwClr  (8'h00),
      .value  (perPri[i])
    );
  end

  // ****************************************
  // Read mux
  // ****************************************
  tic_seq_t seqState_q;
  logic     isrHigh_q;
  logic     isrLow_q;

  // Unmapped offsets read as zero and ignore writes
  always_comb
  begin
    rdByte = 8'h00;
    if (hit(wb_adr_i, OFS_CTRL))   rdByte = ctrlVal;
    if (hit(wb_adr_i, OFS_CTRL2))  rdByte = ctrl2Val & MASK_CTRL2;
    if (hit(wb_adr_i, OFS_CTRL3))  rdByte = ctrl3Val & MASK_CTRL3;
    if (hit(wb_adr_i, OFS_RSTCTL)) rdByte = rstCtlVal & MASK_RSTCTL;
    if (hit(wb_adr_i, OFS_STATUS)) rdByte = {6'h00, isrLow_q, isrHigh_q};
    for (int k = 0; k < NUM_PER_REGS; k++)
    begin
      if (hit(wb_adr_i, 8'(OFS_PFLAG0 + 8'(4 * k)))) rdByte = perFlag[k];
      if (hit(wb_adr_i, 8'(OFS_PEN0 + 8'(4 * k))))   rdByte = perEn[k];
      if (hit(wb_adr_i, 8'(OFS_PPRI0 + 8'(4 * k))))  rdByte = perPri[k];
    end
  end

  // ****************************************
  // Request evaluation
  // ****************************************
  logic                priorityModeEnable;
  logic                globalOrHighLevelEnable;
  logic                peripheralOrLowLevelEnable;
  logic [NUM_CORE-1:0] coreAct;
  logic [NUM_CORE-1:0] corePri;
  logic                perAny;
  logic                perHi;
  logic                perLo;
  logic                takeHigh;
  logic                takeLow;
  logic                respond;

  assign priorityModeEnable         = rstCtlVal[RSTCTL_PRIO];
  assign globalOrHighLevelEnable    = ctrlVal[CTRL_GH];
  assign peripheralOrLowLevelEnable = ctrlVal[CTRL_GL];

  // Core sources: timer, external lines 0..2, port change
  assign coreAct = {ctrlVal[CTRL_TMR_FL] & ctrlVal[CTRL_TMR_EN],
                    ctrlVal[CTRL_E0_FL] & ctrlVal[CTRL_E0_EN],
                    ctrl3Val[CTRL3_E1_FL] & ctrl3Val[CTRL3_E1_EN],
                    ctrl3Val[CTRL3_E2_FL] & ctrl3Val[CTRL3_E2_EN],
                    ctrlVal[CTRL_IOC_FL] & ctrlVal[CTRL_IOC_EN]};
  assign corePri = {ctrl2Val[CTRL2_TMR_PRI], 1'b1,
                    ctrl3Val[CTRL3_E1_PRI], ctrl3Val[CTRL3_E2_PRI],
                    ctrl2Val[CTRL2_IOC_PRI]};

  always_comb
  begin
    perAny = 1'b0;
    perHi  = 1'b0;
    perLo  = 1'b0;
    for (int k = 0; k < NUM_PER_REGS; k++)
    begin
      perAny = perAny | (|(perFlag[k] & perEn[k]));
      perHi  = perHi | (|(perFlag[k] & perEn[k] & perPri[k]));
      perLo  = perLo | (|(perFlag[k] & perEn[k] & ~perPri[k]));
    end
  end

  // Priority bits take no part in compatibility mode
  always_comb
  begin
    if (!priorityModeEnable)
    begin
      takeHigh = globalOrHighLevelEnable & ((|coreAct)
               | (peripheralOrLowLevelEnable & perAny));
      takeLow  = 1'b0;
    end
    else
    begin
      takeHigh = globalOrHighLevelEnable
               & ((|(coreAct & corePri)) | perHi);
      takeLow  = globalOrHighLevelEnable & peripheralOrLowLevelEnable
               & ((|(coreAct & ~corePri)) | perLo)
               & ~isrHigh_q;
    end
  end

  // Only sampled at an instruction boundary
  assign respond = (seqState_q == SEQ_IDLE) & instrEnd
                 & (takeHigh | takeLow);

  // ****************************************
  // Global enable update
  // ****************************************
  logic retSetHigh;
  logic retSetLow;

  // Low routine returns restore the low enable, others the high one
  assign retSetHigh = returnFromIsrInstr
                    & (~priorityModeEnable | ~isrLow_q | isrHigh_q);
  assign retSetLow  = returnFromIsrInstr & priorityModeEnable
                    & isrLow_q & ~isrHigh_q;

  assign ctrlClr = {respond & takeHigh, respond & ~takeHigh, 6'h00};
  assign ctrlSet = {retSetHigh, retSetLow, 3'h0,
                    timerOvfEvt, extEvt[0], iocEvt};

  // ****************************************
  // Vector sequencer
  // ****************************************
  logic            lvlHigh_q;
  logic            stackPush_q;
  logic [PC_W-1:0] stackAddr_q;
  logic            pcLoad_q;
  logic [PC_W-1:0] pcAddr_q;

  // Accept, push and load each take one boundary, so a pin event
  // lands at the third boundary after its flag sets, three clocks after the pin
  always_ff @(posedge ref_clk or negedge rstnSync_q)
  begin
    if (!rstnSync_q)
    begin
      seqState_q  <= SEQ_IDLE;
      lvlHigh_q   <= 1'b0;
      stackPush_q <= 1'b0;
      stackAddr_q <= '0;
      pcLoad_q    <= 1'b0;
      pcAddr_q    <= '0;
    end
    else
    begin
      stackPush_q <= 1'b0;
      pcLoad_q    <= 1'b0;
      unique case (seqState_q)
        SEQ_IDLE:
        begin
          if (respond)
          begin
            lvlHigh_q  <= takeHigh;
            seqState_q <= SEQ_PUSH;
          end
        end
        SEQ_PUSH:
        begin
          if (instrEnd)
          begin
            stackPush_q <= 1'b1;
            stackAddr_q <= returnAddr;
            seqState_q  <= SEQ_LOAD;
          end
        end
        SEQ_LOAD:
        begin
          if (instrEnd)
          begin
            pcLoad_q   <= 1'b1;
            pcAddr_q   <= lvlHigh_q ? VEC_HIGH : VEC_LOW;
            seqState_q <= SEQ_IDLE;
          end
        end
      endcase
    end
  end

  // Routine level tracking; compatibility mode always counts as high
  always_ff @(posedge ref_clk or negedge rstnSync_q)
  begin
    if (!rstnSync_q)
    begin
      isrHigh_q <= 1'b0;
      isrLow_q  <= 1'b0;
    end
    else
    begin
      if (returnFromIsrInstr)
      begin
        if (isrHigh_q)
        begin
          isrHigh_q <= 1'b0;
        end
        else
        begin
          isrLow_q <= 1'b0;
        end
      end
      if (seqState_q == SEQ_LOAD && instrEnd)
      begin
        if (lvlHigh_q)
        begin
          isrHigh_q <= 1'b1;
        end
        else
        begin
          isrLow_q <= 1'b1;
        end
      end
    end
  end

  assign stackPush     = stackPush_q;
  assign stackPushAddr = stackAddr_q;
  assign pcLoad        = pcLoad_q;
  assign pcLoadAddr    = pcAddr_q;
  assign isrHighActive = isrHigh_q;
  assign isrLowActive  = isrLow_q;

  // ****************************************
  // Assertions
  // ****************************************
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!rstnSync_q);

  a_vec_compat: assert property (pcLoad_q && !priorityModeEnable
    |-> pcAddr_q == VEC_HIGH) else $error("compat vector not 0008h");
  a_vec_levels: assert property (pcLoad_q && priorityModeEnable
    |-> pcAddr_q == (lvlHigh_q ? VEC_HIGH : VEC_LOW))
    else $error("priority vector wrong for level");
  a_resp_clears: assert property (respond && takeHigh
    |=> !globalOrHighLevelEnable && seqState_q == SEQ_PUSH)
    else $error("high enable not cleared on response");
  a_push_before_load: assert property (pcLoad_q
    |-> $past(seqState_q) == SEQ_LOAD && !stackPush_q)
    else $error("vector loaded without preceding push");
  a_push_order: assert property (stackPush_q
    |-> seqState_q == SEQ_LOAD && stackAddr_q == $past(returnAddr))
    else $error("push address or order wrong");
  a_no_low_in_high: assert property (pcLoad_q && !lvlHigh_q
    |-> !isrHigh_q) else $error("low taken in high routine");
  a_preempt_low: assert property (priorityModeEnable && isrLow_q
    && globalOrHighLevelEnable && perHi && instrEnd
    && seqState_q == SEQ_IDLE |=> seqState_q == SEQ_PUSH && lvlHigh_q)
    else $error("high request did not preempt low routine");
  a_mask_all: assert property (!globalOrHighLevelEnable
    && seqState_q == SEQ_IDLE |=> seqState_q == SEQ_IDLE)
    else $error("request accepted with global enable clear");
  a_boundary_only: assert property (seqState_q != $past(seqState_q)
    |-> $past(instrEnd)) else $error("sequencer moved off boundary");
  a_return_from_isr_instr_sets: assert property (returnFromIsrInstr && !priorityModeEnable
    && !respond |=> globalOrHighLevelEnable)
    else $error("return did not set global enable");
  a_flag_polls: assert property (periphEvt[0] |=> perFlag[0][0])
    else $error("peripheral flag not set by event");

  c_compat_vec: cover property (pcLoad_q && !priorityModeEnable);
  c_low_vec: cover property (pcLoad_q && priorityModeEnable && !lvlHigh_q);
  c_preempt: cover property (pcLoad_q && lvlHigh_q && isrLow_q);
  c_return_low: cover property (retSetLow);

endmodule // tic_interrupt_controller

// File: sim/tic_cpu_model.sv
// Behavioural core sequencer facing the interrupt controller
`timescale 1ns/1ps
module tic_cpu_model (
  input  wire logic        clk,
  input  wire logic        retReq,
  output logic             instrEnd = 1'b0,
  output logic             returnFromIsrInstr = 1'b0,
  output logic      [15:0] returnAddr = 16'h0000
);
  // ****************************************
  // Boundaries and returns
  // ****************************************
  // Random boundaries, one cycle in three on average, mimic instructions of one cycle or more
  always @(posedge clk)
  begin
    instrEnd <= ($urandom_range(2) == 0);
    returnAddr <= 16'($urandom);
    returnFromIsrInstr <= retReq;
  end
endmodule // tic_cpu_model

// File: sim/test_two_level_interrupt_controller.sv
// Self-checking bench for the two-level interrupt controller
`timescale 1ns/1ps
module test_two_level_interrupt_controller
  import tic_pkg::*;
;
  logic ref_clk = 1'b0, rstn = 1'b0, wbReq = 1'b0, wbWe = 1'b0;
  logic [7:0] wbAdr = 8'h00;
  logic [31:0] wbDatI = '0, wbDatO;
  logic wbAck, timerEvt = 1'b0, retReq = 1'b0, instrEnd, retInstr;
  logic push, load, hiAct, loAct;
  logic [2:0] extPin = '0;
  logic [39:0] perEvt = '0;
  logic [15:0] retAddr, pushAddr, loadAddr, lastRa;
  logic [7:0] ofs[6] = '{8'h00, 8'h04, 8'h08, 8'h50, 8'h70, 8'h7c};
  logic [7:0] rsv[6] = '{8'h00, 8'hf5, 8'hc0, 8'hff, 8'h00, 8'h00};
  int fail_count = 0, n_compared = 0;

  always #12.5 ref_clk = ~ref_clk;

  tic_interrupt_controller tic_interrupt_controller_inst (
    .ref_clk(ref_clk), .rstn(rstn), .wb_cyc_i(wbReq), .wb_stb_i(wbReq),
    .wb_we_i(wbWe), .wb_adr_i(wbAdr), .wb_sel_i(4'h1), .wb_dat_i(wbDatI),
    .wb_dat_o(wbDatO), .wb_ack_o(wbAck), .externalLinePin(extPin),
    .portChangePin(4'h0), .timerOvfEvt(timerEvt), .periphEvt(perEvt),
    .instrEnd(instrEnd), .returnFromIsrInstr(retInstr),
    .returnAddr(retAddr), .stackPush(push), .stackPushAddr(pushAddr),
    .pcLoad(load), .pcLoadAddr(loadAddr), .isrHighActive(hiAct),
    .isrLowActive(loAct));

  tic_cpu_model tic_cpu_model_inst (
    .clk(ref_clk), .retReq(retReq), .instrEnd(instrEnd),
    .returnFromIsrInstr(retInstr), .returnAddr(retAddr));

  // ****************************************
  // Checking and bus tasks
  // ****************************************
  task automatic end_sim;
    if (fail_count == 0 && n_compared > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask

  task automatic hang;
    fail_count++;
    end_sim();
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_compared++;
    if (got !== exp)
    begin
      fail_count++;
      $display("[ERR] %0t got %h exp %h", $time, got, exp);
    end
  endtask

  // Single plain reads and writes only, never a memory-to-memory move
  task automatic wb(input logic we, input logic [7:0] a, input logic [7:0] d,
                    output logic [31:0] q);
    int i;
    wbReq <= 1'b1;
    wbWe <= we;
    wbAdr <= a;
    wbDatI <= {24'h0, d};
    for (i = 0; i < 20 && wbAck !== 1'b1; i++)
      @(posedge ref_clk);
    if (i == 20)
      hang();
    q = wbDatO;
    wbReq <= 1'b0;
    @(posedge ref_clk);
  endtask

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    logic [31:0] q;
    wb(1'b1, a, d, q);
  endtask

  task automatic rd(input logic [7:0] a, input logic [7:0] e);
    logic [31:0] q;
    wb(1'b0, a, 8'h00, q);
    chk(q, {24'h0, e});
  endtask

  // Waits for the vector load, then checks address and routine levels
  task automatic vec(input logic [15:0] ea, input logic eh, input logic el);
    int i;
    for (i = 0; i < 200 && load !== 1'b1; i++)
      @(posedge ref_clk);
    if (i == 200)
      hang();
    chk({14'h0, hiAct, loAct, loadAddr}, {14'h0, eh, el, ea});
  endtask

  always @(posedge ref_clk)
  begin
    if (instrEnd)
      lastRa <= retAddr;
    if (push)
      chk({16'h0, pushAddr}, {16'h0, lastRa});
  end

  // ****************************************
  // Main sequence
  // ****************************************
  initial
  begin
    int s;
    logic [7:0] o;
    s = $urandom(32'h19fc06a1);
    repeat (12) @(posedge ref_clk);
    rstn <= 1'b1;
    repeat (3) @(posedge ref_clk);
    foreach (ofs[k])
      rd(ofs[k], rsv[k]);
    extPin <= 3'b001;
    repeat (6) @(posedge ref_clk);
    rd(OFS_CTRL, 8'h02);
    wr(OFS_CTRL, 8'h00);
    s = $urandom_range(39);
    o = 8'(4 * (s / 8));
    wr(OFS_PEN0 + o, 8'(1 << (s % 8)));
    // Low priority bit must not matter while priority mode is off
    wr(OFS_PPRI0 + o, ~8'(1 << (s % 8)));
    wr(OFS_CTRL, 8'hc0);
    perEvt <= 40'(1) << s;
    @(posedge ref_clk);
    perEvt <= '0;
    vec(VEC_HIGH, 1'b1, 1'b0);
    rd(OFS_CTRL, 8'h40);
    wr(OFS_PFLAG0 + o, 8'h00);
    retReq <= 1'b1;
    @(posedge ref_clk);
    retReq <= 1'b0;
    repeat (3) @(posedge ref_clk);
    rd(OFS_CTRL, 8'hc0);
    wr(OFS_RSTCTL, 8'h80);
    perEvt <= 40'(1) << s;
    @(posedge ref_clk);
    perEvt <= '0;
    vec(VEC_LOW, 1'b0, 1'b1);
    rd(OFS_CTRL, 8'h80);
    wr(OFS_CTRL, 8'ha0);
    timerEvt <= 1'b1;
    @(posedge ref_clk);
    timerEvt <= 1'b0;
    vec(VEC_HIGH, 1'b1, 1'b1);
    rd(OFS_CTRL, 8'h24);
    end_sim();
  end
endmodule // test_two_level_interrupt_controller
